/* inc/gpp_pkg.sv */
// gpp_pkg: constants and carrier types for the general pin port
package gpp_pkg;

    // =====================================================================
    // port geometry
    localparam int unsigned PIN_COUNT   = 16;
    localparam int unsigned DATA_WIDTH  = 32;
    localparam int unsigned ADDR_WIDTH  = 32;
    localparam int unsigned SYNC_STAGES = 2;

    // =====================================================================
    // register byte addresses on the configuration bus
    localparam logic [31:0] ADDR_PIN_ENABLE  = 32'h01B0_0000;
    localparam logic [31:0] ADDR_PIN_DIR     = 32'h01B0_0004;
    localparam logic [31:0] ADDR_PIN_DATA    = 32'h01B0_0008;
    localparam logic [31:0] ADDR_EVENT_EDGE  = 32'h01B0_000C;
    localparam logic [31:0] ADDR_EVENT_ROUTE = 32'h01B0_0010;

    // =====================================================================
    // field layout of the edge select register
    localparam int unsigned EDGE_RISE_LSB = 0;
    localparam int unsigned EDGE_FALL_LSB = 16;

    // =====================================================================
    // reset values
    localparam logic [15:0] PIN_ENABLE_RST  = 16'h00FF;
    localparam logic [15:0] PIN_DIR_RST     = 16'h0000;
    localparam logic [15:0] PIN_DATA_RST    = 16'h0000;
    localparam logic [31:0] EVENT_EDGE_RST  = 32'h0000_0000;
    localparam logic [15:0] EVENT_ROUTE_RST = 16'h0000;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    // =====================================================================
    // register selector produced by the address decoder
    typedef enum {
        GPP_SEL_NONE,
        GPP_SEL_ENABLE,
        GPP_SEL_DIR,
        GPP_SEL_DATA,
        GPP_SEL_EDGE,
        GPP_SEL_ROUTE
    } gpp_sel_e;

    // one configuration bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gpp_req_s;

    // one configuration bus answer
    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
    } gpp_rsp_s;

endpackage : gpp_pkg

/* hdl/gpp_port.sv */
// gpp_port: sixteen general pins behind the processor configuration bus
//
// Function
// RL1: sixteen general pins; a pin works only while its use enable bit is 1.
// RL2: on an enabled pin the direction bit chooses input or output.
// RL3: after reset every direction bit selects input, nothing is driven.
// RL4: an output pin drives the bit software wrote to the data register.
// RL5: reading the data register returns the sensed level of input pins.
// RL6: pin edges raise processor interrupts or DMA events, selectable per pin.
// RL7: board must hold inputs twelve clocks so a polling bus read sees them.
// RL8: after reset the lower eight pins are enabled and act as inputs.
// RL9: a disabled pin ignores direction and data, is not driven, raises nothing.
module gpp_port
    import gpp_pkg::*;
#(
    parameter int unsigned PINS = PIN_COUNT
) (
    // clock, reset, enable
    input  wire logic            ref_clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic            clk_en_i,
    // configuration bus
    input  wire gpp_req_s        cfg_req_i,
    output gpp_rsp_s             cfg_rsp_o,
    // general pins, three signals each
    input  wire logic [PINS-1:0] pin_in_i,
    output logic      [PINS-1:0] pin_out_o,
    output logic      [PINS-1:0] pin_oe_o,
    // pin events toward the processor and the dma controller
    output logic      [PINS-1:0] cpu_int_o,
    output logic      [PINS-1:0] dma_evt_o
);

    // =====================================================================
    // address decode, shared by the bus logic and the checks
    function automatic gpp_sel_e decode_sel(input logic [31:0] addr);
        gpp_sel_e sel;
        sel = GPP_SEL_NONE;
        case (addr)
            ADDR_PIN_ENABLE:  sel = GPP_SEL_ENABLE;
            ADDR_PIN_DIR:     sel = GPP_SEL_DIR;
            ADDR_PIN_DATA:    sel = GPP_SEL_DATA;
            ADDR_EVENT_EDGE:  sel = GPP_SEL_EDGE;
            ADDR_EVENT_ROUTE: sel = GPP_SEL_ROUTE;
            default:          sel = GPP_SEL_NONE;
        endcase
        return sel;
    endfunction : decode_sel

    // =====================================================================
    // state
    logic [PINS-1:0] pin_enable;
    logic [PINS-1:0] pin_dir;
    logic [PINS-1:0] pin_data;
    logic [PINS-1:0] edge_rise;
    logic [PINS-1:0] edge_fall;
    logic [PINS-1:0] evt_route;
    logic [PINS-1:0] in_meta;
    logic [PINS-1:0] in_sync;
    logic [PINS-1:0] in_prev;

    logic [PINS-1:0] next_pin_enable;
    logic [PINS-1:0] next_pin_dir;
    logic [PINS-1:0] next_pin_data;
    logic [PINS-1:0] next_edge_rise;
    logic [PINS-1:0] next_edge_fall;
    logic [PINS-1:0] next_evt_route;
    gpp_rsp_s        next_cfg_rsp;
    logic [PINS-1:0] next_pin_out;
    logic [PINS-1:0] next_pin_oe;
    logic [PINS-1:0] next_cpu_int;
    logic [PINS-1:0] next_dma_evt;

    logic [PINS-1:0] is_input;
    logic [PINS-1:0] is_output;
    logic [PINS-1:0] edge_hit;
    gpp_sel_e        req_sel;

    // =====================================================================
    // per pin role and edge detection
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            // disabled pins fall out of both roles
            assign is_input[g]  = pin_enable[g] & ~pin_dir[g];          // see RL2 see RL9
            assign is_output[g] = pin_enable[g] &  pin_dir[g];          // see RL2 see RL9
            // compares synced history only, never the first stage
            assign edge_hit[g]  = is_input[g] &                         // see RL6
                ((edge_rise[g] &  in_sync[g] & ~in_prev[g]) |
                 (edge_fall[g] & ~in_sync[g] &  in_prev[g]));
        end
    endgenerate

    assign req_sel = decode_sel(cfg_req_i.addr);

    // =====================================================================
    // configuration registers and bus answer, next values
    always_comb begin
        next_pin_enable = pin_enable;
        next_pin_dir    = pin_dir;
        next_pin_data   = pin_data;
        next_edge_rise  = edge_rise;
        next_edge_fall  = edge_fall;
        next_evt_route  = evt_route;
        next_cfg_rsp    = '{rdata: READ_ZERO, ack: 1'b0};
        if (cfg_req_i.wr) begin
            case (req_sel)
                GPP_SEL_ENABLE: next_pin_enable = cfg_req_i.wdata[PINS-1:0];   // see RL1
                GPP_SEL_DIR:    next_pin_dir    = cfg_req_i.wdata[PINS-1:0];   // see RL2
                GPP_SEL_DATA:   next_pin_data   = cfg_req_i.wdata[PINS-1:0];   // see RL4
                GPP_SEL_EDGE: begin
                    next_edge_rise = cfg_req_i.wdata[EDGE_RISE_LSB +: PINS];
                    next_edge_fall = cfg_req_i.wdata[EDGE_FALL_LSB +: PINS];
                end
                GPP_SEL_ROUTE:  next_evt_route  = cfg_req_i.wdata[PINS-1:0];
                default: ;
            endcase
        end
        // a write and a read in one cycle both get the single answer
        if (cfg_req_i.wr || cfg_req_i.rd) begin
            next_cfg_rsp.ack = 1'b1;
        end
        if (cfg_req_i.rd) begin
            case (req_sel)
                GPP_SEL_ENABLE: next_cfg_rsp.rdata[PINS-1:0] = pin_enable;
                GPP_SEL_DIR:    next_cfg_rsp.rdata[PINS-1:0] = pin_dir;
                // inputs show the sensed level, outputs the written bit
                GPP_SEL_DATA:   next_cfg_rsp.rdata[PINS-1:0] =
                    (in_sync & is_input) | (pin_data & is_output);         // see RL5 see RL7
                GPP_SEL_EDGE: begin
                    next_cfg_rsp.rdata[EDGE_RISE_LSB +: PINS] = edge_rise;
                    next_cfg_rsp.rdata[EDGE_FALL_LSB +: PINS] = edge_fall;
                end
                GPP_SEL_ROUTE:  next_cfg_rsp.rdata[PINS-1:0] = evt_route;
                default:        next_cfg_rsp.rdata = READ_ZERO;
            endcase
        end
    end

    // registered; reset wins over a frozen clock enable
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_enable <= PIN_ENABLE_RST;                                   // see RL8
            pin_dir    <= PIN_DIR_RST;                                      // see RL3 see RL8
            pin_data   <= PIN_DATA_RST;
            edge_rise  <= EVENT_EDGE_RST[EDGE_RISE_LSB +: PINS];
            edge_fall  <= EVENT_EDGE_RST[EDGE_FALL_LSB +: PINS];
            evt_route  <= EVENT_ROUTE_RST;
            cfg_rsp_o  <= '{rdata: READ_ZERO, ack: 1'b0};
        end else if (clk_en_i) begin
            pin_enable <= next_pin_enable;
            pin_dir    <= next_pin_dir;
            pin_data   <= next_pin_data;
            edge_rise  <= next_edge_rise;
            edge_fall  <= next_edge_fall;
            evt_route  <= next_evt_route;
            cfg_rsp_o  <= next_cfg_rsp;
        end
    end

    // =====================================================================
    // pin drive and events, next values
    always_comb begin
        next_pin_oe  = is_output;                                           // see RL2 see RL9
        next_pin_out = pin_data & is_output;                                // see RL4
        // route bit set sends the event to dma, clear to the processor
        next_cpu_int = edge_hit & ~evt_route;                               // see RL6
        next_dma_evt = edge_hit &  evt_route;                               // see RL6
    end

    // two flops on every pin before any logic looks at it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            in_meta   <= '0;
            in_sync   <= '0;
            in_prev   <= '0;
            pin_out_o <= '0;
            pin_oe_o  <= '0;                                                // see RL3
            cpu_int_o <= '0;
            dma_evt_o <= '0;
        end else if (clk_en_i) begin
            in_meta   <= pin_in_i;
            in_sync   <= in_meta;
            in_prev   <= in_sync;
            pin_out_o <= next_pin_out;
            pin_oe_o  <= next_pin_oe;
            cpu_int_o <= next_cpu_int;
            dma_evt_o <= next_dma_evt;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence data_write_s;
        clk_en_i && cfg_req_i.wr && decode_sel(cfg_req_i.addr) == GPP_SEL_DATA;
    endsequence

    sequence rise_seen_s;
        clk_en_i && |(is_input & edge_rise & in_sync & ~in_prev);
    endsequence

    reset_state_a: assert property ($fell(sys_rst_i) |->                    // see RL8
        pin_enable == PIN_ENABLE_RST && pin_dir == PIN_DIR_RST && pin_oe_o == '0)
        else $error("port state wrong after reset");

    no_drive_input_a: assert property (clk_en_i |=>                          // see RL3
        (pin_oe_o & ~$past(pin_dir)) == '0)
        else $error("pin driven while its direction is input");

    disabled_quiet_a: assert property (clk_en_i |=>                          // see RL9
        ((pin_oe_o | cpu_int_o | dma_evt_o) & ~$past(pin_enable)) == '0)
        else $error("disabled pin driven or raised an event");

    out_follows_a: assert property (data_write_s ##1 clk_en_i |=>            // see RL4
        (pin_out_o & pin_oe_o) == ($past(cfg_req_i.wdata[PINS-1:0], 2) & pin_oe_o))
        else $error("output pin does not show written data");

    read_sensed_a: assert property (clk_en_i && cfg_req_i.rd &&              // see RL5
        decode_sel(cfg_req_i.addr) == GPP_SEL_DATA |=>
        (cfg_rsp_o.rdata[PINS-1:0] & $past(is_input)) == $past(in_sync & is_input))
        else $error("data read misses an input level");

    rise_event_a: assert property (rise_seen_s |=>                           // see RL6
        (cpu_int_o | dma_evt_o) != '0)
        else $error("rising edge raised no event");

    // each pulse must land on the target its route bit picked, never on both
    route_split_a: assert property (clk_en_i |=>                             // see RL6
        ((cpu_int_o & $past(evt_route)) | (dma_evt_o & ~$past(evt_route))) == '0)
        else $error("event sent to the wrong target");

    bus_answer_a: assert property (clk_en_i && (cfg_req_i.rd || cfg_req_i.wr)  // see RL1
        |=> cfg_rsp_o.ack ##1 (!$past(clk_en_i) || cfg_rsp_o.ack == $past(
        cfg_req_i.rd || cfg_req_i.wr)))
        else $error("bus answer late or stray");

endmodule : gpp_port

/* verif/gpp_board.sv */
// gpp_board: board logic that senses and drives the sixteen general pins
module gpp_board
    import gpp_pkg::*;
(
    // levels the board wants to put on its side
    input  wire logic [PIN_COUNT-1:0] drive_i,
    // device side of each pin
    input  wire logic [PIN_COUNT-1:0] pin_out_i,
    input  wire logic [PIN_COUNT-1:0] pin_oe_i,
    // resolved wire level fed back to the device
    output logic      [PIN_COUNT-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // wire resolution
    // a driven pin shows the device value, otherwise the board level, held
    // by the bench for at least twelve clocks so polling can see it
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drive_i);
endmodule : gpp_board

/* verif/gpp_port_test.sv */
// gpp_port_test: self-checking bench for the general pin port
module gpp_port_test
    import gpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } gpp_row_s;

    logic            ref_clk_i = 1'b0;
    logic            sys_rst_i;
    logic            clk_en_i;
    gpp_req_s        req;
    gpp_rsp_s        rsp;
    logic [15:0]     drive;
    logic [15:0]     level;
    logic [15:0]     pin_out;
    logic [15:0]     pin_oe;
    logic [15:0]     cpu_int;
    logic [15:0]     dma_evt;
    logic [31:0]     rd_val;
    logic [15:0]     cpu_acc;
    logic [15:0]     dma_acc;
    int              error_cnt = 0;
    int              comparisons = 0;
    gpp_row_s        rows [5];

    // =====================================================================
    // clock, device and board
    always #12.5 ref_clk_i = ~ref_clk_i;

    gpp_port uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .cfg_req_i(req), .cfg_rsp_o(rsp), .pin_in_i(level), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .cpu_int_o(cpu_int), .dma_evt_o(dma_evt));

    gpp_board board (.drive_i(drive), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .level_o(level));

    // =====================================================================
    // shared tasks
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    // one-cycle request pulse, answer waited for under a bounded count
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        req = '{addr: a, wdata: d, wr: w, rd: !w};
        @(negedge ref_clk_i);
        req.wr = 1'b0;
        req.rd = 1'b0;
        while (n < 4 && rsp.ack !== 1'b1) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 4) chk("ack", 32'h1, 32'h0);
        rd_val = rsp.rdata;
    endtask : bus

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rd_val);
    endtask : rd_chk

    // events are pulses, so collect them over a window
    task automatic ev_chk(input logic [15:0] pins, input logic [15:0] ec, input logic [15:0] ed);
        @(negedge ref_clk_i);
        drive = pins;
        cpu_acc = '0;
        dma_acc = '0;
        repeat (12) begin
            @(negedge ref_clk_i);
            cpu_acc |= cpu_int;
            dma_acc |= dma_evt;
        end
        chk("cpu_int", {16'h0, ec}, {16'h0, cpu_acc});
        chk("dma_evt", {16'h0, ed}, {16'h0, dma_acc});
    endtask : ev_chk

    task automatic rst_chk();
        @(negedge ref_clk_i);
        sys_rst_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk("pin_oe", 32'h0, {16'h0, pin_oe});
        rd_chk("enable", ADDR_PIN_ENABLE, 32'h0000_00FF);
        rd_chk("direction", ADDR_PIN_DIR, 32'h0);
        $display("test reset done");
    endtask : rst_chk

    task automatic wrap_up();
        $display("counts: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // =====================================================================
    // main sequence: table of register rows, then hand-written cases
    initial begin
        sys_rst_i = 1'b1;
        clk_en_i = 1'b1;
        req = '0;
        drive = '0;
        rows = '{'{ADDR_PIN_ENABLE, 32'hFFFF_FFFF, 32'h0000_FFFF},
                 '{ADDR_PIN_DIR, 32'hFFFF_0000, 32'h0},
                 '{ADDR_EVENT_EDGE, 32'h1234_5678, 32'h1234_5678},
                 '{ADDR_EVENT_ROUTE, 32'hFFFF_0001, 32'h0000_0001},
                 '{32'h01B0_0014, 32'h0000_A5A5, 32'h0}};
        rst_chk();
        foreach (rows[i]) begin
            bus(1'b1, rows[i].addr, rows[i].wdata);
            rd_chk("register row", rows[i].addr, rows[i].exp);
        end
        $display("test register rows done");
        // outputs on enabled pins only; disabled pins 8..11 stay undriven
        bus(1'b1, ADDR_PIN_ENABLE, 32'h0000_00FF);
        bus(1'b1, ADDR_PIN_DIR, 32'h0000_0F0F);
        bus(1'b1, ADDR_PIN_DATA, 32'h0000_A5A5);
        repeat (2) @(negedge ref_clk_i);
        chk("pin_oe", 32'h0000_000F, {16'h0, pin_oe});
        chk("pin_out", 32'h0000_0005, {16'h0, pin_out});
        $display("test output drive done");
        // polling read: board holds levels twelve clocks first
        drive = 16'h3C3C;
        repeat (12) @(negedge ref_clk_i);
        rd_chk("data", ADDR_PIN_DATA, 32'h0000_0035);
        $display("test input poll done");
        // rise on 4,5,12, fall on 6; pin 5 to dma, pin 12 disabled
        bus(1'b1, ADDR_EVENT_EDGE, 32'h0040_1030);
        bus(1'b1, ADDR_EVENT_ROUTE, 32'h0000_0020);
        ev_chk(16'h0000, 16'h0, 16'h0);
        ev_chk(16'h1070, 16'h0010, 16'h0020);
        ev_chk(16'h0000, 16'h0040, 16'h0);
        $display("test events done");
        // frozen enable: a held write and a pin rise both wait for it
        @(negedge ref_clk_i);
        clk_en_i = 1'b0;
        drive = 16'h0010;
        req = '{addr: ADDR_PIN_DATA, wdata: 32'h0000_000A, wr: 1'b1, rd: 1'b0};
        cpu_acc = '0;
        repeat (8) begin
            @(negedge ref_clk_i);
            cpu_acc |= cpu_int;
        end
        chk("frozen ack", 32'h0, {31'h0, rsp.ack});
        chk("frozen pin_out", 32'h0000_0005, {16'h0, pin_out});
        chk("frozen cpu_int", 32'h0, {16'h0, cpu_acc});
        clk_en_i = 1'b1;
        @(negedge ref_clk_i);
        req = '0;
        chk("late ack", 32'h1, {31'h0, rsp.ack});
        ev_chk(16'h0010, 16'h0010, 16'h0);
        chk("thawed pin_out", 32'h0000_000A, {16'h0, pin_out});
        rd_chk("thawed data", ADDR_PIN_DATA, 32'h0000_001A);
        $display("test clock enable done");
        rst_chk();
        wrap_up();
    end

    // watchdog well past the expected run of about 130 cycles
    initial begin
        #100us;
        error_cnt++;
        wrap_up();
    end
endmodule : gpp_port_test
